// *** design/sfp_flash_cmds.sv ***
// program and erase command handling of a serial nor flash
// Functional notes
// - program needs the write-enable latch set
// - 02h short or long address, 12h long
// - chip select must rise after whole byte
// - valid program starts timed op, busy set
// - protected program sets error
// - programming only clears bits
// - four-line mode moves everything on four lines
// - 32h/34h address like 02h/12h, nibble data
// - quad program needs quad enable and latch
// - 20h/21h erase sector to all ones
// - sector erase needs the latch set
// - erase chip select must rise after address
// - busy held through erase, then cleared
// - protected sector erase refused, error set
// - 52h/53h erase half block to ones
// - address bit 15 picks block half
// - any protected sector blocks half erase
// - four-line mode carries erase command too
// - page is 256 aligned bytes
// - four-line mode takes nibbles per edge
`timescale 1ns/1ps
`default_nettype none
module sfp_flash_cmds
	import sfp_pkg::*;
#(
	parameter int PROG_TIME_NS = PROG_TIME_NS_DEF,
	parameter int SECTOR_ERASE_NS = SECTOR_ERASE_NS_DEF,
	parameter int HALF_ERASE_NS = HALF_ERASE_NS_DEF
) (
	// system clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// serial link from the host
	input wire logic spi_sck_in,
	input wire logic spi_cs_n_in,
	input wire logic [3:0] spi_io_in,
	output logic [3:0] spi_io_out,
	output logic [3:0] spi_io_oe_out,
	// configuration and status
	input wire logic [7:0] config_two_volatile_in,
	input wire logic quad_enable_in,
	input wire logic clear_err_in,
	output logic [7:0] status_one_volatile_out,
	output logic [7:0] status_two_volatile_out,
	// protection lookup, answered in the same cycle
	output logic [19:0] prot_sector_out,
	input wire logic prot_locked_in,
	// flash array port
	output logic [31:0] array_addr_out,
	output logic array_rd_out,
	input wire logic [7:0] array_rdata_in,
	output logic array_wr_out,
	output logic [7:0] array_wdata_out,
	output logic array_erase_out,
	output logic array_erase_half_out
);

	// operation lengths in system clock cycles, never below one
	localparam int PROG_CYC_RAW = PROG_TIME_NS / CLK_PERIOD_NS;
	localparam int SE_CYC_RAW = SECTOR_ERASE_NS / CLK_PERIOD_NS;
	localparam int HB_CYC_RAW = HALF_ERASE_NS / CLK_PERIOD_NS;
	localparam logic [31:0] PROG_CYC = 32'(PROG_CYC_RAW > 0 ? PROG_CYC_RAW : 1);
	localparam logic [31:0] SE_CYC = 32'(SE_CYC_RAW > 0 ? SE_CYC_RAW : 1);
	localparam logic [31:0] HB_CYC = 32'(HB_CYC_RAW > 0 ? HB_CYC_RAW : 1);

	// the device never drives the io lines for these commands
	assign spi_io_out = 4'h0;
	assign spi_io_oe_out = 4'h0;

	// configuration frozen while a frame is open, read by the link side
	logic [7:0] cfg_hold;

	// link side: per-frame state, cleared while chip select is high
	logic [7:0] shift;
	logic [2:0] bit_cnt;
	logic [5:0] byte_cnt;
	logic first_edge;
	logic [7:0] op;
	// link side: results held after the frame for the system side
	logic frame_tog;
	logic data_tog;
	logic pub_boundary;
	logic [5:0] pub_nbytes;
	logic [7:0] pub_op;
	logic [31:0] pub_addr;
	logic [7:0] pub_data;
	logic [7:0] pub_col;
	logic [7:0] data_col;

	// link side decode of the current edge
	logic [7:0] cur_op;
	logic [5:0] cur_alen;
	logic nibble;
	logic byte_done;
	logic [7:0] new_byte;
	logic [5:0] next_byte_cnt;

	// opcode is the byte being finished on the first byte
	always_comb
	begin
		cur_op = (byte_cnt == 6'h00) ? new_byte : op;
		cur_alen = addr_len(op, cfg_hold[CFG_ADDR_LEN_BIT]);
		if (byte_cnt == 6'h00)
			nibble = cfg_hold[CFG_FOUR_LINE_BIT];
		else if (byte_cnt <= cur_alen)
			nibble = cfg_hold[CFG_FOUR_LINE_BIT];
		else // data phase: four lines in quad program or four-line mode
			nibble = cfg_hold[CFG_FOUR_LINE_BIT] || is_quad(op);
		byte_done = nibble ? (bit_cnt == 3'h4) : (bit_cnt == 3'h7);
		new_byte = nibble ? {shift[3:0], spi_io_in}
			: {shift[6:0], spi_io_in[0]};
		next_byte_cnt = (byte_cnt == 6'h3F) ? byte_cnt : byte_cnt + 6'h01;
	end

	// bit and byte counting; chip select high clears it asynchronously
	always_ff @(posedge spi_sck_in or posedge spi_cs_n_in)
	begin
		if (spi_cs_n_in)
		begin
			shift <= 8'h00;
			bit_cnt <= 3'h0;
			byte_cnt <= 6'h00;
			first_edge <= 1'b1;
			op <= 8'h00;
		end
		else
		begin
			shift <= new_byte;
			first_edge <= 1'b0;
			// whole byte: restart the bit count
			if (byte_done)
			begin
				bit_cnt <= 3'h0;
				byte_cnt <= next_byte_cnt;
			end
			else
				bit_cnt <= bit_cnt + (nibble ? 3'h4 : 3'h1);
			if (byte_done && byte_cnt == 6'h00)
				op <= new_byte;
		end
	end

	// results survive chip select so the system side can read them
	// after the clock has stopped
	always_ff @(posedge spi_sck_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			frame_tog <= 1'b0;
			data_tog <= 1'b0;
			pub_boundary <= 1'b0;
			pub_nbytes <= 6'h00;
			pub_op <= 8'h00;
			pub_addr <= 32'h0000_0000;
			pub_data <= 8'h00;
			pub_col <= 8'h00;
			data_col <= 8'h00;
		end
		else
		begin
			// one toggle per frame marks a frame with clock edges
			if (first_edge)
				frame_tog <= ~frame_tog;
			// legal end only right after a complete byte
			pub_boundary <= byte_done;
			if (first_edge)
				pub_nbytes <= byte_done ? 6'h01 : 6'h00;
			else if (byte_done)
				pub_nbytes <= next_byte_cnt;
			if (byte_done)
			begin
				if (byte_cnt == 6'h00)
				begin
					pub_op <= cur_op;
					pub_addr <= 32'h0000_0000;
				end
				else if (byte_cnt <= cur_alen)
				begin
					pub_addr <= {pub_addr[23:0], new_byte};
					// last address byte gives the starting column
					if (byte_cnt == cur_alen)
						data_col <= new_byte;
				end
				else if (is_program(op))
				begin
					pub_data <= new_byte;
					pub_col <= data_col;
					data_col <= data_col + 8'h01;
					data_tog <= ~data_tog;
				end
			end
		end
	end

	// system side: bring chip select and the toggles across
	logic [2:0] sync_q;
	logic cs_s;
	logic cs_d;
	logic frame_s;
	logic frame_seen;
	logic data_s;
	logic data_d;

	sfp_sync #(
		.WIDTH(3)
	) u_sync (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.async_in({spi_cs_n_in, frame_tog, data_tog}),
		.sync_out(sync_q)
	);

	assign cs_s = sync_q[2];
	assign frame_s = sync_q[1];
	assign data_s = sync_q[0];

	// sequencer state
	sfp_state_t state;
	logic busy;
	logic wen_latch;
	logic prog_err;
	logic erase_err;
	logic [7:0] run_op;
	logic [31:0] run_addr;
	logic [19:0] chk_base;
	logic [3:0] chk_idx;
	logic [3:0] chk_cnt;
	logic [7:0] col;
	logic [31:0] timer;
	logic [7:0] page_buf [0:255];
	logic [255:0] loaded;

	// frame decode at the rising chip select
	logic cs_rise;
	logic new_frame;
	logic [5:0] frm_alen;
	logic take_wen;
	logic take_prog;
	logic take_erase;

	always_comb
	begin
		cs_rise = cs_s && !cs_d;
		new_frame = cs_rise && (frame_s != frame_seen) && pub_boundary;
		frm_alen = addr_len(pub_op, cfg_hold[CFG_ADDR_LEN_BIT]);
		take_wen = new_frame && !busy && (pub_op == WRITE_ENABLE_CMD)
			&& (pub_nbytes == 6'h01);
		// quad program also needs the quad enable bit
		take_prog = new_frame && !busy && wen_latch && is_program(pub_op)
			&& (!is_quad(pub_op) || quad_enable_in)
			&& (pub_nbytes >= frm_alen + 6'h02);
		// erase must end exactly after the last address byte
		take_erase = new_frame && !busy && wen_latch && is_erase(pub_op)
			&& (pub_nbytes == frm_alen + 6'h01);
	end

	assign busy = (state != ST_IDLE);

	// edge history and frame bookkeeping
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			cs_d <= 1'b1;
			data_d <= 1'b0;
			frame_seen <= 1'b0;
			cfg_hold <= 8'h00;
		end
		else
		begin
			cs_d <= cs_s;
			data_d <= data_s;
			if (cs_rise)
				frame_seen <= frame_s;
			// freeze configuration while a frame is open
			if (cs_s && cs_d)
				cfg_hold <= config_two_volatile_in;
		end
	end

	// page buffer load; untouched while an operation runs
	always_ff @(posedge clk_in)
	begin
		if (data_s != data_d && !busy)
			page_buf[pub_col] <= pub_data;
	end

	// loaded-byte mask, cleared when a new frame opens while idle
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			loaded <= '0;
		else if (!busy && !cs_s && cs_d)
			loaded <= '0;
		else if (data_s != data_d && !busy)
			loaded[pub_col] <= 1'b1;
	end

	// write-enable latch: set by its command, dropped at operation end
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			wen_latch <= 1'b0;
		else if (take_wen)
			wen_latch <= 1'b1;
		else if (state == ST_TIMED && timer == 32'h0000_0001)
			wen_latch <= 1'b0;
		else if (state == ST_CHECK && prot_locked_in)
			wen_latch <= 1'b0;
	end

	// sticky error flags; a new error wins over a clear
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			prog_err <= 1'b0;
			erase_err <= 1'b0;
		end
		else
		begin
			if (state == ST_CHECK && prot_locked_in && is_program(run_op))
				prog_err <= 1'b1;
			else if (clear_err_in)
				prog_err <= 1'b0;
			if (state == ST_CHECK && prot_locked_in && is_erase(run_op))
				erase_err <= 1'b1;
			else if (clear_err_in)
				erase_err <= 1'b0;
		end
	end

	// main sequencer: protection check, array work, timed wait
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state <= ST_IDLE;
			run_op <= 8'h00;
			run_addr <= 32'h0000_0000;
			chk_base <= 20'h00000;
			chk_idx <= 4'h0;
			chk_cnt <= 4'h0;
			col <= 8'h00;
			timer <= 32'h0000_0000;
		end
		else
		begin
			unique case (state)
				ST_IDLE:
				begin
					// accept a command at a legal chip select rise
					if (take_prog || take_erase)
					begin
						state <= ST_CHECK;
						run_op <= pub_op;
						run_addr <= pub_addr;
						chk_idx <= 4'h0;
						col <= 8'h00;
						if (is_half(pub_op))
						begin
							// lower or upper eight sectors of the block
							chk_base <= {pub_addr[31:HALF_SEL_BIT], 3'h0};
							chk_cnt <= HALF_BLOCK_SECTORS;
						end
						else
						begin
							chk_base <= pub_addr[31:SECTOR_SHIFT];
							chk_cnt <= ONE_SECTOR;
						end
					end
				end
				ST_CHECK:
				begin
					// one locked sector cancels the whole range
					if (prot_locked_in)
						state <= ST_IDLE;
					else if (chk_idx + 4'h1 == chk_cnt)
						state <= is_program(run_op) ? ST_PREAD : ST_ERASE;
					else
						chk_idx <= chk_idx + 4'h1;
				end
				ST_PREAD:
				begin
					// skip columns the host did not load
					if (loaded[col])
						state <= ST_PWAIT;
					else if (col == PAGE_LAST_COL)
					begin
						state <= ST_TIMED;
						timer <= PROG_CYC;
					end
					else
						col <= col + 8'h01;
				end
				ST_PWAIT:
					state <= ST_PWRITE;
				ST_PWRITE:
				begin
					if (col == PAGE_LAST_COL)
					begin
						state <= ST_TIMED;
						timer <= PROG_CYC;
					end
					else
					begin
						state <= ST_PREAD;
						col <= col + 8'h01;
					end
				end
				ST_ERASE:
				begin
					state <= ST_TIMED;
					timer <= is_half(run_op) ? HB_CYC : SE_CYC;
				end
				ST_TIMED:
				begin
					// busy holds until the operation time has run out
					if (timer == 32'h0000_0001)
						state <= ST_IDLE;
					else
						timer <= timer - 32'h0000_0001;
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// array port outputs, registered
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			array_addr_out <= 32'h0000_0000;
			array_rd_out <= 1'b0;
			array_wr_out <= 1'b0;
			array_wdata_out <= 8'h00;
			array_erase_out <= 1'b0;
			array_erase_half_out <= 1'b0;
		end
		else
		begin
			array_rd_out <= (state == ST_PREAD) && loaded[col];
			array_wr_out <= (state == ST_PWRITE);
			array_erase_out <= (state == ST_ERASE);
			array_erase_half_out <= (state == ST_ERASE) && is_half(run_op);
			if (state == ST_PREAD)
				array_addr_out <= {run_addr[31:8], col};
			else if (state == ST_ERASE)
				array_addr_out <= is_half(run_op)
					? {run_addr[31:HALF_SEL_BIT], 15'h0000}
					: {run_addr[31:SECTOR_SHIFT], 12'h000};
			// old data anded in, so a zero is never written back as a one
			if (state == ST_PWRITE)
				array_wdata_out <= array_rdata_in & page_buf[col];
		end
	end

	// protection lookup address, status bytes
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			prot_sector_out <= 20'h00000;
			status_one_volatile_out <= 8'h00;
			status_two_volatile_out <= 8'h00;
		end
		else
		begin
			// lead the check by a cycle so each index is ready in time
			prot_sector_out <= (state == ST_CHECK && !prot_locked_in)
				? chk_base + 20'(chk_idx) + 20'h00001
				: (take_prog || take_erase)
				? (is_half(pub_op) ? {pub_addr[31:HALF_SEL_BIT], 3'h0}
					: pub_addr[31:SECTOR_SHIFT])
				: prot_sector_out;
			status_one_volatile_out <= 8'h00;
			status_one_volatile_out[ST1_BUSY_BIT] <= busy;
			status_one_volatile_out[ST1_WEN_BIT] <= wen_latch;
			status_two_volatile_out <= 8'h00;
			status_two_volatile_out[ST2_PROG_ERR_BIT] <= prog_err;
			status_two_volatile_out[ST2_ERASE_ERR_BIT] <= erase_err;
		end
	end

endmodule : sfp_flash_cmds
`default_nettype wire

// *** design/sfp_pkg.sv ***
// constants, types and decode helpers for the flash program/erase block
package sfp_pkg;

	// opcodes decoded by this block
	localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
	localparam logic [7:0] PAGE_PROGRAM_WIDE_ADDR_CMD = 8'h12;
	localparam logic [7:0] QUAD_PAGE_PROGRAM_CMD = 8'h32;
	localparam logic [7:0] QUAD_PAGE_PROGRAM_WIDE_ADDR_CMD = 8'h34;
	localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
	localparam logic [7:0] SECTOR_ERASE_WIDE_ADDR_CMD = 8'h21;
	localparam logic [7:0] HALF_BLOCK_ERASE_CMD = 8'h52;
	localparam logic [7:0] HALF_BLOCK_ERASE_WIDE_ADDR_CMD = 8'h53;

	// field positions in the configuration and status bytes
	localparam int CFG_ADDR_LEN_BIT = 0;
	localparam int CFG_FOUR_LINE_BIT = 3;
	localparam int ST1_BUSY_BIT = 0;
	localparam int ST1_WEN_BIT = 1;
	localparam int ST2_PROG_ERR_BIT = 5;
	localparam int ST2_ERASE_ERR_BIT = 6;

	// address lengths in bytes
	localparam logic [5:0] ADDR_BYTES_SHORT = 6'h03;
	localparam logic [5:0] ADDR_BYTES_LONG = 6'h04;

	// array geometry
	localparam int SECTOR_SHIFT = 12;
	localparam int HALF_SEL_BIT = 15;
	localparam logic [3:0] HALF_BLOCK_SECTORS = 4'h8;
	localparam logic [3:0] ONE_SECTOR = 4'h1;
	localparam logic [7:0] PAGE_LAST_COL = 8'hFF;

	// clock rate and default operation times
	localparam int CLK_PERIOD_NS = 4;
	localparam int PROG_TIME_NS_DEF = 500000;
	localparam int SECTOR_ERASE_NS_DEF = 50000000;
	localparam int HALF_ERASE_NS_DEF = 200000000;

	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CHECK = 3'b001,
		ST_PREAD = 3'b010,
		ST_PWAIT = 3'b011,
		ST_PWRITE = 3'b100,
		ST_ERASE = 3'b101,
		ST_TIMED = 3'b110
	} sfp_state_t;

	// true for the long-address opcode variants
	function automatic logic is_wide(input logic [7:0] op);
		is_wide = (op == PAGE_PROGRAM_WIDE_ADDR_CMD)
			|| (op == QUAD_PAGE_PROGRAM_WIDE_ADDR_CMD)
			|| (op == SECTOR_ERASE_WIDE_ADDR_CMD)
			|| (op == HALF_BLOCK_ERASE_WIDE_ADDR_CMD);
	endfunction : is_wide

	// address byte count of an opcode under the address-length bit
	function automatic logic [5:0] addr_len(input logic [7:0] op,
		input logic long_addr);
		addr_len = (is_wide(op) || long_addr) ? ADDR_BYTES_LONG
			: ADDR_BYTES_SHORT;
	endfunction : addr_len

	// quad-data program opcodes
	function automatic logic is_quad(input logic [7:0] op);
		is_quad = (op == QUAD_PAGE_PROGRAM_CMD)
			|| (op == QUAD_PAGE_PROGRAM_WIDE_ADDR_CMD);
	endfunction : is_quad

	// all program opcodes
	function automatic logic is_program(input logic [7:0] op);
		is_program = is_quad(op) || (op == PAGE_PROGRAM_CMD)
			|| (op == PAGE_PROGRAM_WIDE_ADDR_CMD);
	endfunction : is_program

	// half-block erase opcodes
	function automatic logic is_half(input logic [7:0] op);
		is_half = (op == HALF_BLOCK_ERASE_CMD)
			|| (op == HALF_BLOCK_ERASE_WIDE_ADDR_CMD);
	endfunction : is_half

	// all erase opcodes
	function automatic logic is_erase(input logic [7:0] op);
		is_erase = is_half(op) || (op == SECTOR_ERASE_CMD)
			|| (op == SECTOR_ERASE_WIDE_ADDR_CMD);
	endfunction : is_erase

endpackage : sfp_pkg

// *** design/sfp_sync.sv ***
// two-flop level synchroniser into the system clock domain
`timescale 1ns/1ps
`default_nettype none
module sfp_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// levels from the other domain
	input wire logic [WIDTH-1:0] async_in,
	// synchronised levels
	output logic [WIDTH-1:0] sync_out
);

	// first stage is read by the second stage only
	logic [WIDTH-1:0] meta;

	// two back-to-back stages
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			meta <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule : sfp_sync
`default_nettype wire

// *** dv/sfp_flash_cmds_chk.sv ***
// assertion checker for the flash program and erase block
`timescale 1ns/1ps
`default_nettype none
module sfp_flash_cmds_chk
	import sfp_pkg::*;
#(
	parameter int PROG_TIME_NS = PROG_TIME_NS_DEF
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// link and status
	input wire logic spi_cs_n_in,
	input wire logic [3:0] spi_io_oe_out,
	input wire logic [7:0] status_one_volatile_out,
	input wire logic [7:0] status_two_volatile_out,
	// array port
	input wire logic [31:0] array_addr_out,
	input wire logic array_rd_out,
	input wire logic [7:0] array_rdata_in,
	input wire logic array_wr_out,
	input wire logic [7:0] array_wdata_out,
	input wire logic array_erase_out,
	input wire logic array_erase_half_out
);
	// shortest busy stretch, the program time in clocks
	localparam int MIN_BUSY = PROG_TIME_NS / CLK_PERIOD_NS;
	logic rd_d; // read strobe, delayed to the data cycle
	logic [7:0] old_q; // array byte before programming
	logic [15:0] busy_cnt; // length of the running busy stretch
	logic busy;
	logic wen;
	assign busy = status_one_volatile_out[0];
	assign wen = status_one_volatile_out[1];
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	// old byte capture, used to prove that programming only clears bits
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			rd_d <= 1'b0;
			old_q <= 8'h00;
		end
		else
		begin
			rd_d <= array_rd_out;
			if (rd_d)
				old_q <= array_rdata_in;
		end
	end
	// busy length counter, wide enough for the longest erase used
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			busy_cnt <= 16'h0000;
		else
			busy_cnt <= busy ? busy_cnt + 16'h0001 : 16'h0000;
	end
	AST_NO_IO_DRIVE: assert property (spi_io_oe_out == 4'h0)
		else $error("io lines driven");
	AST_WR_AFTER_RD: assert property (array_rd_out |-> ##2 array_wr_out)
		else $error("no write after read");
	AST_ONLY_CLEARS: assert property (array_wr_out
		|-> (array_wdata_out & ~old_q) == 8'h00)
		else $error("program sets a bit");
	AST_WR_NEEDS_WEN: assert property (array_wr_out |-> wen)
		else $error("write without latch");
	AST_ER_NEEDS_WEN: assert property (array_erase_out |-> wen && spi_cs_n_in)
		else $error("erase without latch");
	AST_HALF_PAIRED: assert property (array_erase_half_out |-> array_erase_out)
		else $error("half flag alone");
	AST_ER_ALIGN: assert property (array_erase_out
		|-> array_addr_out[11:0] == 12'h000
		&& (!array_erase_half_out || array_addr_out[14:12] == 3'h0))
		else $error("erase base misaligned");
	AST_ER_BUSY: assert property (array_erase_out |-> ##[1:3] busy)
		else $error("erase without busy");
	AST_ERR_NO_ERASE: assert property ($rose(status_two_volatile_out[6]) |-> !array_erase_out [*8])
		else $error("erase despite protection");
	AST_BUSY_LEN: assert property ($fell(busy) && status_two_volatile_out == 8'h00 |-> busy_cnt >= MIN_BUSY)
		else $error("busy too short");
	AST_WEN_DROP: assert property ($fell(busy) && status_two_volatile_out == 8'h00 |-> !wen)
		else $error("latch kept after op");
	// main scenarios reached
	COV_WRITE: cover property (array_wr_out);
	COV_HALF: cover property (array_erase_half_out);
	COV_ERASE_ERR: cover property ($rose(status_two_volatile_out[6]));
endmodule : sfp_flash_cmds_chk
bind sfp_flash_cmds sfp_flash_cmds_chk #(.PROG_TIME_NS(PROG_TIME_NS)) u_chk (
	.clk_in(clk_in), .nrst_in(nrst_in), .spi_cs_n_in(spi_cs_n_in),
	.spi_io_oe_out(spi_io_oe_out),
	.status_one_volatile_out(status_one_volatile_out),
	.status_two_volatile_out(status_two_volatile_out),
	.array_addr_out(array_addr_out), .array_rd_out(array_rd_out),
	.array_rdata_in(array_rdata_in), .array_wr_out(array_wr_out),
	.array_wdata_out(array_wdata_out), .array_erase_out(array_erase_out),
	.array_erase_half_out(array_erase_half_out));
`default_nettype wire

// *** dv/sfp_flash_cmds_test.sv ***
// testbench for the flash program and erase block
`timescale 1ns/1ps
`default_nettype none
module sfp_flash_cmds_test;
	import sfp_pkg::*;
	logic clk_in, nrst_in, quad_enable_in, clear_err_in, lock_en;
	logic [7:0] cfg, rdata;
	logic [19:0] lock_sec; // the one protected sector
	wire logic sck, cs_n, ard, awr, aer, ahalf, prot_locked_in;
	wire logic [3:0] io, dio;
	wire logic [7:0] st1, st2, wdata;
	wire logic [19:0] psec;
	wire logic [31:0] aaddr;
	logic [7:0] mem[logic [31:0]]; // array contents, absent means erased
	logic [41:0] exp_q[$]; // notes: erase, half, address, data
	logic [7:0] ops[8] = '{8'h02, 8'h12, 8'h32, 8'h34, 8'h20, 8'h21, 8'h52, 8'h53};
	int fail_count, n_compared;
	// protection lookup answers in the same cycle
	assign prot_locked_in = lock_en && psec == lock_sec;
	initial
	begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	sfp_host host (.sck_out(sck), .cs_n_out(cs_n), .io_out(io));
	// long half erase keeps busy across a whole frame
	sfp_flash_cmds #(.PROG_TIME_NS(40), .SECTOR_ERASE_NS(80), .HALF_ERASE_NS(8000)) dut (
		.clk_in(clk_in), .nrst_in(nrst_in), .spi_sck_in(sck), .spi_cs_n_in(cs_n),
		.spi_io_in(io), .spi_io_out(dio), .spi_io_oe_out(),
		.config_two_volatile_in(cfg), .quad_enable_in(quad_enable_in),
		.clear_err_in(clear_err_in), .status_one_volatile_out(st1),
		.status_two_volatile_out(st2), .prot_sector_out(psec),
		.prot_locked_in(prot_locked_in), .array_addr_out(aaddr),
		.array_rd_out(ard), .array_rdata_in(rdata), .array_wr_out(awr),
		.array_wdata_out(wdata), .array_erase_out(aer),
		.array_erase_half_out(ahalf));
	function automatic logic [7:0] rd_mem(input logic [31:0] a);
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction : rd_mem
	// array model: data the cycle after a read, else a moving pattern
	always @(posedge clk_in)
	begin
		rdata <= ard ? rd_mem(aaddr) : ~rdata;
		if (awr)
			mem[aaddr] = wdata;
		if (aer)
			for (int i = 0; i < (ahalf ? 32768 : 4096); i++)
				mem[aaddr + i] = 8'hFF;
	end
	// monitor: every array write or erase takes the oldest note
	always @(posedge clk_in)
		if (awr || aer)
		begin
			n_compared++;
			if (exp_q.size() == 0 || exp_q[0] !== {aer, ahalf, aaddr, aer ? 8'h00 : wdata})
			begin
				$display("[ERR] %0t array op %h", $time, {aer, ahalf, aaddr, wdata});
				fail_count++;
			end
			if (exp_q.size() != 0)
				void'(exp_q.pop_front());
		end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
			fail_count++;
		end
	endtask : chk
	// command frame with its expected array operations
	task automatic run(input logic [7:0] op, input logic [31:0] a, input int n,
		input bit ok, input int ex);
		logic [7:0] b[$];
		logic [41:0] nq[$]; // this frame's writes
		logic [7:0] d;
		logic [31:0] ca;
		bit wide;
		bit hb;
		int al;
		wide = cfg[0] || op inside {8'h12, 8'h34, 8'h21, 8'h53};
		al = wide ? 4 : 3;
		hb = op inside {8'h52, 8'h53};
		if (!wide)
			a[31:24] = 8'h00;
		b.push_back(op);
		for (int i = al - 1; i >= 0; i--)
			b.push_back(a[8 * i +: 8]);
		for (int k = 0; k < n; k++)
		begin
			d = $urandom;
			ca = {a[31:8], a[7:0] + k[7:0]}; // stays in the page
			if (!op[5])
				mem[ca] = $urandom; // quad targets stay erased
			b.push_back(d);
			if (ok)
				nq.push_back({2'b00, ca, d & rd_mem(ca)});
		end
		// the page is written from column 0 up, so wrapped bytes go first
		nq.sort();
		foreach (nq[j])
			exp_q.push_back(nq[j]);
		if (ok && n == 0)
			exp_q.push_back({1'b1, hb, hb ? {a[31:15], 15'h0000} : {a[31:12], 12'h000}, 8'h00});
		host.frame(b, al + 1, cfg[3], cfg[3] || op inside {8'h32, 8'h34}, ex);
	endtask : run
	task automatic write_enable_cmd;
		logic [7:0] b[$];
		// a cfg set by nonblocking assignment is read only after an edge
		@(posedge clk_in);
		b.push_back(WRITE_ENABLE_CMD);
		host.frame(b, 1, cfg[3], cfg[3], 0);
		chk(st1, 8'h02, "latch");
	endtask : write_enable_cmd
	// wait out busy under a bound, then check both status bytes
	task automatic settle(input logic [7:0] s1, input logic [7:0] s2);
		for (int i = 0; i < 3000 && st1[0] !== 1'b0; i++)
			@(posedge clk_in);
		@(posedge clk_in);
		chk(st1, s1, "status one");
		chk(st2, s2, "status two");
		chk({4'h0, dio}, 8'h00, "io lines");
	endtask : settle
	task automatic clr;
		@(posedge clk_in) clear_err_in <= 1'b1;
		@(posedge clk_in) clear_err_in <= 1'b0;
	endtask : clr
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	initial
	begin
		#380000;
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test();
	end
	initial
	begin
		void'($urandom(32'hAF930169));
		nrst_in = 1'b0;
		cfg = 8'h00;
		quad_enable_in = 1'b1;
		clear_err_in = 1'b0;
		lock_en = 1'b0;
		lock_sec = 20'h00135;
		rdata = 8'h00;
		fail_count = 0;
		n_compared = 0;
		repeat (6) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		settle(8'h00, 8'h00);
		run(8'h02, $urandom, 2, 0, 0);
		settle(8'h00, 8'h00);
		// every opcode under both address lengths and both line modes
		foreach (ops[i])
			for (int m = 0; m < 4; m++)
			begin
				@(posedge clk_in) cfg <= {4'h0, m[1], 2'b00, m[0]};
				write_enable_cmd();
				run(ops[i], $urandom, i < 4 ? 1 + $urandom % 4 : 0, 1, 0);
				settle(8'h00, 8'h00);
			end
		@(posedge clk_in) cfg <= 8'h00;
		write_enable_cmd();
		run(8'h02, 32'h000012FE, 3, 1, 0);
		settle(8'h00, 8'h00);
		write_enable_cmd();
		run(8'h02, $urandom, 1, 0, 3);
		settle(8'h02, 8'h00);
		run(8'h20, $urandom, 0, 0, 8);
		settle(8'h02, 8'h00);
		@(posedge clk_in) quad_enable_in <= 1'b0;
		run(8'h32, $urandom, 2, 0, 0);
		settle(8'h02, 8'h00);
		@(posedge clk_in) quad_enable_in <= 1'b1;
		run(8'h52, 32'h00128000, 0, 1, 0);
		run(8'h20, 32'h00010000, 0, 0, 0);
		settle(8'h00, 8'h00);
		@(posedge clk_in) lock_en <= 1'b1;
		write_enable_cmd();
		run(8'h20, 32'h00135ABC, 0, 0, 0);
		settle(8'h00, 8'h40);
		clr();
		write_enable_cmd();
		run(8'h52, 32'h00130000, 0, 0, 0);
		settle(8'h00, 8'h40);
		clr();
		write_enable_cmd();
		run(8'h02, 32'h00135010, 2, 0, 0);
		settle(8'h00, 8'h20);
		clr();
		write_enable_cmd();
		run(8'h52, 32'h00138000, 0, 1, 0);
		settle(8'h00, 8'h00);
		if (exp_q.size() != 0)
		begin
			$display("[ERR] %0t array ops missing", $time);
			fail_count++;
		end
		stop_test();
	end
endmodule : sfp_flash_cmds_test
`default_nettype wire

// *** dv/sfp_host.sv ***
// host serial controller model that sends command frames
`timescale 1ns/1ps
`default_nettype none
module sfp_host (
	// serial link toward the device
	output logic sck_out,
	output logic cs_n_out,
	output logic [3:0] io_out
);
	// idle: clock stopped, select high
	initial
	begin
		sck_out = 1'b0;
		cs_n_out = 1'b0;
		io_out = 4'hA;
		// a clean rising select clears the link side before any frame
		#1 cs_n_out = 1'b1;
	end
	// one 80 ns clock, data set while low, well under 133 MHz
	task automatic bit_out(input logic [3:0] v);
		io_out = v;
		#20 sck_out = 1'b1;
		#40 sck_out = 1'b0;
		#20;
	endtask : bit_out
	// frame: hn header bytes on h4 width, data on d4 width, ex stray edges
	task automatic frame(input logic [7:0] b[$], input int hn, input bit h4,
		input bit d4, input int ex);
		int w;
		cs_n_out = 1'b0;
		#40;
		for (int i = 0; i < b.size(); i++)
		begin
			w = (i < hn ? h4 : d4) ? 4 : 1;
			for (int k = 0; k < 8 / w; k++)
				bit_out(w == 4 ? b[i][7 - 4 * k -: 4] : {~io_out[3:1], b[i][7 - k]});
		end
		// stray edges only where a scenario wants a broken frame
		for (int k = 0; k < ex; k++)
			bit_out(~io_out);
		#40;
		cs_n_out = 1'b1; // rises after a whole unit unless the ex stray edges leave a partial one
		io_out = ~io_out; // released lines keep no stale value
		#200;
	endtask : frame
endmodule : sfp_host
`default_nettype wire
